// ### design/dcr_core.sv
// DDR2 device-side command decoder, bank tracker, posted column queue,
// auto-precharge timers, refresh counter, self refresh control and burst order.
// Assumes a controller that keeps its own timing rules (tRCD, tRFC, tCCD, tXSNR).
`timescale 1ns/1ps

// Functional notes
// - Read with A10 high precharges its bank AL plus BL/2 cycles later.
// - A10 high selects auto-precharge; A10 low leaves the row open.
// - Write with A10 high precharges after burst end plus write recovery.
// - Precharge encoding with A10 high idles every bank, bank bits ignored.
// - Refresh with CKE low enters self refresh; only CKE is watched there.
// - DLL turns off entering self refresh and back on when leaving.
// - In self refresh the clock is gated and an internal timer refreshes.
// - Refresh with CKE high uses the internal row counter, inputs ignored.
// - Refresh idles all banks; controller spaces next command by tRFC.
// - NOP encoding takes no action, same as deselect.
// - CS high disables the decoder entirely.
// - Bursts stay inside aligned groups of four or eight columns.
// - Column commands accepted any time after activate, issued AL later.
// - Read latency is AL plus CL; write latency is one less.
// - Additive latency settings zero through six are supported.
// - BL8 interleave fully; BL8 sequential wraps inside each nibble.
module dcr_core
	import dcr_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic                  clk_en,
	input  wire logic                  cke,
	input  wire dcr_pins_t             pins,
	input  wire logic [BANK_W-1:0]     ba,
	input  wire logic [ADDR_W-1:0]     addr,
	input  wire dcr_mode_t             mode,
	output logic [NUM_BANKS-1:0]       bank_active,
	output logic                       self_refresh,
	output logic                       dll_on,
	output logic                       int_clk_on,
	output logic                       refresh_pulse,
	output logic [ROW_W-1:0]           refresh_row,
	output dcr_col_t                   col_issue,
	output logic                       burst_valid,
	output logic                       burst_write,
	output logic [COL_W-1:0]           burst_col_even,
	output logic [COL_W-1:0]           burst_col_odd,
	output logic [LAT_W-1:0]           read_lat,
	output logic [LAT_W-1:0]           write_lat
);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic dcr_cmd_t dcr_decode(input dcr_pins_t p);
		dcr_cmd_t c;
		c = CMD_NOP;
		if (!p.cs_n) begin
			case ({p.ras_n, p.cas_n, p.we_n})
				3'h3:    c = CMD_ACT;
				3'h5:    c = CMD_RD;
				3'h4:    c = CMD_WR;
				3'h2:    c = CMD_PRE;
				3'h1:    c = CMD_REF;
				3'h0:    c = CMD_MRS;
				default: c = CMD_NOP;
			endcase
		end
		return c;
	endfunction : dcr_decode

	// Column of beat idx within the aligned group of the start column
	function automatic logic [COL_W-1:0] dcr_beat(input logic [COL_W-1:0] start, input logic [2:0] idx,
	                                              input logic bl8, input logic il);
		logic [COL_W-1:0] c;
		logic [1:0]       low;
		c   = start;
		low = il ? (start[1:0] ^ idx[1:0]) : (start[1:0] + idx[1:0]);
		c[1:0] = low;
		if (bl8) begin
			c[2] = start[2] ^ idx[2];
		end
		return c;
	endfunction : dcr_beat

	// ------------------------------------------------------------
	// Command decode and power state
	// ------------------------------------------------------------
	dcr_cmd_t cmd_raw;
	dcr_cmd_t cmd_now;
	dcr_pwr_t pwr;
	logic     cke_prev;
	logic     sr_enter;
	logic     sr_exit;
	logic     col_cmd;

	assign cmd_raw  = dcr_decode(pins);
	assign sr_enter = (pwr == PWR_NORMAL) && cke_prev && !cke && (cmd_raw == CMD_REF);
	assign sr_exit  = (pwr == PWR_SELF) && cke;
	// Only CKE counts while self refreshing; both edges of CKE block decoding
	assign cmd_now  = ((pwr == PWR_NORMAL) && cke && cke_prev) ? cmd_raw : CMD_NOP;
	assign col_cmd  = (cmd_now == CMD_RD) || (cmd_now == CMD_WR);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cke_prev <= 1'b0;
		end else if (clk_en) begin
			cke_prev <= cke;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pwr <= PWR_NORMAL;
		end else if (clk_en) begin
			case (pwr)
				PWR_NORMAL: if (sr_enter) begin
					pwr <= PWR_SELF;
				end
				PWR_SELF: if (sr_exit) begin
					pwr <= PWR_NORMAL;
				end
				default: pwr <= PWR_NORMAL;
			endcase
		end
	end

	assign self_refresh = (pwr == PWR_SELF);
	assign dll_on       = (pwr == PWR_NORMAL);
	assign int_clk_on   = (pwr == PWR_NORMAL);

	// ------------------------------------------------------------
	// Refresh row counter and self refresh timer
	// ------------------------------------------------------------
	logic [SR_TICK_W-1:0] sr_timer;
	logic                 sr_tick;

	assign sr_tick = (pwr == PWR_SELF) && (sr_timer == SR_TICK_W'(SR_TICK_CYC - 1));

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sr_timer <= '0;
		end else if (clk_en) begin
			if (pwr != PWR_SELF || sr_tick) begin
				sr_timer <= '0;
			end else begin
				sr_timer <= sr_timer + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			refresh_row   <= '0;
			refresh_pulse <= 1'b0;
		end else if (clk_en) begin
			refresh_pulse <= (cmd_now == CMD_REF) || sr_tick;
			// Address pins never reach the row counter
			if ((cmd_now == CMD_REF) || sr_tick) begin
				refresh_row <= refresh_row + 1'b1;
			end
		end else begin
			refresh_pulse <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Auto-precharge timers
	// ------------------------------------------------------------
	logic [CNT_W-1:0] ap_cnt [NUM_BANKS];
	logic [NUM_BANKS-1:0] ap_fire;
	logic [CNT_W-1:0] half_bl;
	logic [CNT_W-1:0] rd_ap_delay;
	logic [CNT_W-1:0] wr_ap_delay;

	assign half_bl     = CNT_W'(mode.bl8 ? HALF_BL8 : HALF_BL4);
	assign rd_ap_delay = CNT_W'(mode.al) + half_bl;
	// Write latency, burst and write recovery all counted from the command edge
	assign wr_ap_delay = CNT_W'(mode.al) + CNT_W'(mode.cl) - 1'b1 + half_bl + CNT_W'(mode.wr);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int b = 0; b < NUM_BANKS; b++) begin
				ap_cnt[b] <= '0;
			end
		end else if (clk_en) begin
			for (int b = 0; b < NUM_BANKS; b++) begin
				if (col_cmd && addr[AP_BIT] && (ba == BANK_W'(b))) begin
					ap_cnt[b] <= (cmd_now == CMD_RD) ? rd_ap_delay : wr_ap_delay;
				end else if ((cmd_now == CMD_PRE && addr[AP_BIT]) || cmd_now == CMD_REF) begin
					ap_cnt[b] <= '0;
				end else if (ap_cnt[b] != '0) begin
					ap_cnt[b] <= ap_cnt[b] - 1'b1;
				end
			end
		end
	end

	always_comb begin
		for (int b = 0; b < NUM_BANKS; b++) begin
			ap_fire[b] = (ap_cnt[b] == CNT_W'(1));
		end
	end

	// ------------------------------------------------------------
	// Bank state
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bank_active <= '0;
		end else if (clk_en) begin
			if (cmd_now == CMD_REF || (cmd_now == CMD_PRE && addr[AP_BIT])) begin
				bank_active <= '0;
			end else begin
				for (int b = 0; b < NUM_BANKS; b++) begin
					if (cmd_now == CMD_ACT && ba == BANK_W'(b)) begin
						bank_active[b] <= 1'b1;
					end else if (ap_fire[b] || (cmd_now == CMD_PRE && ba == BANK_W'(b))) begin
						bank_active[b] <= 1'b0;
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Posted column queue
	// ------------------------------------------------------------
	dcr_col_t col_in;
	dcr_col_t col_pipe [AL_MAX];
	dcr_col_t next_col_issue;

	always_comb begin
		col_in          = '0;
		col_in.valid    = col_cmd;
		col_in.write    = (cmd_now == CMD_WR);
		col_in.auto_pre = addr[AP_BIT];
		col_in.bank     = ba;
		col_in.col      = addr[COL_W-1:0];
	end

	// No bank state check here: the command waits AL cycles before use
	assign next_col_issue = (mode.al == 3'h0) ? col_in : col_pipe[mode.al - 3'h1];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < AL_MAX; i++) begin
				col_pipe[i] <= '0;
			end
			col_issue <= '0;
		end else if (clk_en) begin
			col_pipe[0] <= col_in;
			for (int i = 1; i < AL_MAX; i++) begin
				col_pipe[i] <= col_pipe[i-1];
			end
			col_issue <= next_col_issue;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			read_lat  <= '0;
			write_lat <= '0;
		end else if (clk_en) begin
			read_lat  <= LAT_W'(mode.al) + LAT_W'(mode.cl);
			write_lat <= LAT_W'(mode.al) + LAT_W'(mode.cl) - 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Burst column order
	// ------------------------------------------------------------
	logic [COL_W-1:0] burst_start;
	logic [1:0]       burst_pair;
	logic             burst_bl8;
	logic             burst_il;
	logic [1:0]       next_pair;

	assign next_pair = burst_pair + 1'b1;

	// A new column restarts the burst, which is how an allowed BL8 interrupt lands
	always_ff @(posedge core_clk) begin
		if (rst) begin
			burst_valid    <= 1'b0;
			burst_write    <= 1'b0;
			burst_start    <= '0;
			burst_pair     <= '0;
			burst_bl8      <= 1'b0;
			burst_il       <= 1'b0;
			burst_col_even <= '0;
			burst_col_odd  <= '0;
		end else if (clk_en) begin
			if (next_col_issue.valid) begin
				burst_valid    <= 1'b1;
				burst_write    <= next_col_issue.write;
				burst_start    <= next_col_issue.col;
				burst_pair     <= '0;
				burst_bl8      <= mode.bl8;
				burst_il       <= mode.interleave;
				burst_col_even <= dcr_beat(next_col_issue.col, 3'h0, mode.bl8, mode.interleave);
				burst_col_odd  <= dcr_beat(next_col_issue.col, 3'h1, mode.bl8, mode.interleave);
			end else if (burst_valid) begin
				if (burst_pair == (burst_bl8 ? LAST_PAIR_BL8 : LAST_PAIR_BL4)) begin
					burst_valid <= 1'b0;
				end else begin
					burst_pair     <= next_pair;
					burst_col_even <= dcr_beat(burst_start, {next_pair, 1'b0}, burst_bl8, burst_il);
					burst_col_odd  <= dcr_beat(burst_start, {next_pair, 1'b1}, burst_bl8, burst_il);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_prea_idles_all: assert property (@(posedge core_clk) disable iff (rst)
		(clk_en && cmd_now == CMD_PRE && addr[AP_BIT]) |=> (bank_active == '0))
		else $error("precharge all left a bank active");

	a_ref_row_step: assert property (@(posedge core_clk) disable iff (rst)
		(clk_en && cmd_now == CMD_REF) |=> (bank_active == '0) && (refresh_row == $past(refresh_row) + 1'b1))
		else $error("refresh did not idle banks or step the row counter");

	a_sr_dll_off: assert property (@(posedge core_clk) disable iff (rst)
		(clk_en && sr_enter) |=> (self_refresh && !dll_on && !int_clk_on))
		else $error("self refresh entry did not stop dll and clock");

	a_sr_holds: assert property (@(posedge core_clk) disable iff (rst)
		(self_refresh && !cke) |=> (self_refresh && $stable(bank_active) && !col_in.valid))
		else $error("self refresh left or reacted to inputs while cke low");

	a_nop_no_action: assert property (@(posedge core_clk) disable iff (rst)
		(clk_en && cmd_now == CMD_NOP && ap_fire == '0) |=> $stable(bank_active))
		else $error("nop or deselect changed bank state");

	a_rd_ap_timing: assert property (@(posedge core_clk) disable iff (rst)
		(clk_en && cmd_now == CMD_RD && addr[AP_BIT] && mode.al == 3'h0 && !mode.bl8) ##1
		(clk_en && cmd_now == CMD_NOP) ##1 (clk_en && cmd_now != CMD_ACT) |=> !bank_active[$past(ba, 3)])
		else $error("read auto precharge not at AL plus BL/2");

	a_posted_col: assert property (@(posedge core_clk) disable iff (rst)
		(clk_en && col_cmd && mode.al == 3'h2) ##1 clk_en[*2] |=>
		(col_issue.valid && col_issue.col == $past(addr[COL_W-1:0], 3)))
		else $error("posted column not issued after additive latency");

	a_lat_relation: assert property (@(posedge core_clk) disable iff (rst)
		clk_en |=> (read_lat == LAT_W'($past(mode.al)) + LAT_W'($past(mode.cl))) && (write_lat == read_lat - 1'b1))
		else $error("read or write latency wrong");

	a_burst_group: assert property (@(posedge core_clk) disable iff (rst)
		(burst_valid && burst_bl8) |-> (burst_col_even[COL_W-1:GRP8_LSB] == burst_start[COL_W-1:GRP8_LSB]) &&
		(burst_col_odd[COL_W-1:GRP8_LSB] == burst_start[COL_W-1:GRP8_LSB]))
		else $error("burst left its aligned group");

	a_burst4_group: assert property (@(posedge core_clk) disable iff (rst)
		(burst_valid && !burst_bl8) |-> (burst_col_odd[COL_W-1:GRP4_LSB] == burst_start[COL_W-1:GRP4_LSB]))
		else $error("four beat burst left its group");

endmodule : dcr_core

// ### include/dcr_pkg.sv
// Shared types and constants for the DDR2 command, refresh and column access block.
// Assumes the command pins are already registered on the rising edge of core_clk.
package dcr_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int unsigned NUM_BANKS  = 4;
	localparam int unsigned BANK_W     = 2;
	localparam int unsigned ADDR_W     = 12;
	localparam int unsigned COL_W      = 9;
	localparam int unsigned ROW_W      = 12;
	localparam int unsigned AP_BIT     = 10;
	localparam int unsigned GRP4_LSB   = 2;
	localparam int unsigned GRP8_LSB   = 3;
	localparam int unsigned AL_MAX     = 6;
	localparam int unsigned LAT_W      = 4;
	localparam int unsigned CNT_W      = 5;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS  = 4000;
	localparam int unsigned SR_TICK_NS     = 7800;
	// Longest interval: rounds down to whole cycles
	localparam int unsigned SR_TICK_CYC    = (SR_TICK_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned SR_TICK_W      = 12;
	localparam logic [2:0]  HALF_BL4       = 3'h2;
	localparam logic [2:0]  HALF_BL8       = 3'h4;
	localparam logic [1:0]  LAST_PAIR_BL4  = 2'h1;
	localparam logic [1:0]  LAST_PAIR_BL8  = 2'h3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} dcr_pins_t;

	typedef struct packed {
		logic [2:0] al;
		logic [2:0] cl;
		logic [2:0] wr;
		logic       bl8;
		logic       interleave;
	} dcr_mode_t;

	typedef struct packed {
		logic              valid;
		logic              write;
		logic              auto_pre;
		logic [BANK_W-1:0] bank;
		logic [COL_W-1:0]  col;
	} dcr_col_t;

	typedef enum logic [2:0] {
		CMD_NOP,
		CMD_ACT,
		CMD_RD,
		CMD_WR,
		CMD_PRE,
		CMD_REF,
		CMD_MRS
	} dcr_cmd_t;

	typedef enum logic {
		PWR_NORMAL,
		PWR_SELF
	} dcr_pwr_t;

endpackage : dcr_pkg

// ### test/dcr_ctrl_model.sv
// Controller-side model: turns bench requests into DDR2 command pins.
// Assumes requests change by non-blocking assignment just after core_clk rises.
`timescale 1ns/1ps
module dcr_ctrl_model
	import dcr_pkg::*;
(
	input  wire logic              core_clk,
	input  wire dcr_cmd_t          req_cmd,
	input  wire logic              req_cke,
	input  wire logic [BANK_W-1:0] req_ba,
	input  wire logic [ADDR_W-1:0] req_addr,
	output logic                   cke,
	output dcr_pins_t              pins,
	output logic [BANK_W-1:0]      ba,
	output logic [ADDR_W-1:0]      addr,
	output logic                   odt
);
	logic [31:0] noise;

	// Fresh filler each cycle so ignored pins never hold a settled value
	always_ff @(posedge core_clk) begin
		noise <= $urandom;
	end

	always_comb begin
		cke  = req_cke;
		odt  = 1'b0;
		ba   = req_ba;
		addr = req_addr;
		case (req_cmd)
			CMD_ACT: pins = 4'h3;
			CMD_RD:  pins = 4'h5;
			CMD_WR:  pins = 4'h4;
			CMD_PRE: pins = 4'h2;
			CMD_REF: pins = 4'h1;
			CMD_MRS: pins = 4'h0;
			default: begin
				// Idle slot: deselect with junk, or a clean no-operation
				pins = noise[4] ? {1'b1, noise[2:0]} : 4'h7;
				ba   = noise[6:5];
				addr = noise[18:7];
			end
		endcase
		// With CKE low and no command requested every other pin but ODT is junk
		if (!req_cke && req_cmd == CMD_NOP) begin
			pins = noise[3:0];
		end
	end
endmodule : dcr_ctrl_model

// ### test/ddr2_command_refresh_access_tb_top.sv
// Self-checking bench for dcr_core, commands sent through dcr_ctrl_model.
// Assumes the core checks no controller timing; the bench spaces commands itself.
`timescale 1ns/1ps
module ddr2_command_refresh_access_tb_top
	import dcr_pkg::*;
;
	localparam int TRFC_CYC  = 30;
	localparam int TXSNR_CYC = 50;
	localparam int LIMIT     = 20000;

	logic                 core_clk;
	logic                 rst;
	logic                 clk_en;
	logic                 req_cke;
	dcr_cmd_t             req_cmd;
	logic [BANK_W-1:0]    req_ba;
	logic [ADDR_W-1:0]    req_addr;
	logic                 cke;
	logic                 odt;
	dcr_pins_t            pins;
	logic [BANK_W-1:0]    ba;
	logic [ADDR_W-1:0]    addr;
	dcr_mode_t            mode;
	logic [NUM_BANKS-1:0] bank_active;
	logic                 self_refresh, dll_on, int_clk_on, refresh_pulse, burst_valid, burst_write;
	logic [ROW_W-1:0]     refresh_row, exp_row;
	dcr_col_t             col_issue;
	logic [COL_W-1:0]     burst_col_even, burst_col_odd;
	logic [LAT_W-1:0]     read_lat, write_lat;
	int                   err_total = 0;
	int                   compares = 0;
	int                   cyc = 0;
	int                   pulses = 0;
	int                   p0;

	dcr_ctrl_model ctrl (.core_clk, .req_cmd, .req_cke, .req_ba, .req_addr, .cke, .pins, .ba, .addr, .odt);
	dcr_core dut (.core_clk, .rst, .clk_en, .cke, .pins, .ba, .addr, .mode, .bank_active, .self_refresh,
		.dll_on, .int_clk_on, .refresh_pulse, .refresh_row, .col_issue, .burst_valid, .burst_write,
		.burst_col_even, .burst_col_odd, .read_lat, .write_lat);

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cyc++;
		if (cyc >= LIMIT) begin
			err_total++;
			close_out();
		end
	end

	// Counted mid-cycle so the registered pulse has settled
	always @(negedge core_clk) begin
		if (refresh_pulse === 1'b1) pulses++;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want) begin
			err_total++;
			$display("Error at time %0t: seen %0h expected %0h", $time, seen, want);
		end
	endtask : check

	task automatic close_out;
		if (err_total == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out

	// Request holds until the caller changes it; returns just after the taking edge
	task automatic send(input dcr_cmd_t c, input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a);
		req_cmd  <= c;
		req_ba   <= b;
		req_addr <= a;
		@(posedge core_clk);
		#1;
	endtask : send

	task automatic idle(input int n);
		req_cmd <= CMD_NOP;
		repeat (n) @(posedge core_clk);
		#1;
	endtask : idle

	function automatic logic [COL_W-1:0] beat(input logic [COL_W-1:0] c, input int i);
		logic [2:0] l;
		if (!mode.bl8) l = {c[2], mode.interleave ? c[1:0] ^ i[1:0] : c[1:0] + i[1:0]};
		else if (mode.interleave) l = c[2:0] ^ i[2:0];
		else l = {c[2] ^ i[2], c[1:0] + i[1:0]};
		return {c[8:3], l};
	endfunction : beat

	// Activate then a column command on the very next cycle, walked edge by edge
	task automatic access(input logic w, input logic ap);
		logic [BANK_W-1:0] b;
		logic [COL_W-1:0]  c;
		int                hb, lat, n, j;
		b = BANK_W'($urandom);
		c = COL_W'($urandom);
		hb = mode.bl8 ? 4 : 2;
		lat = mode.al;
		n = w ? lat + mode.cl - 1 + hb + mode.wr : lat + hb;
		send(CMD_ACT, b, ADDR_W'($urandom));
		send(w ? CMD_WR : CMD_RD, b, {1'b0, ap, 1'b0, c});
		// K counts edges after the column edge; values seen were registered at edge k
		for (int k = 0; k <= n + 1; k++) begin
			if (k > 0) begin
				idle(1);
			end
			j = k - lat;
			check(col_issue.valid, k == lat);
			if (k == lat) begin
				check({col_issue.write, col_issue.auto_pre, col_issue.bank, col_issue.col}, {w, ap, b, c});
			end
			check(burst_valid, j >= 0 && j < hb);
			if (j >= 0 && j < hb) begin
				check({burst_write, burst_col_even, burst_col_odd}, {w, beat(c, 2 * j), beat(c, 2 * j + 1)});
			end
			check(bank_active[b], !ap || k < n);
		end
		send(CMD_PRE, BANK_W'($urandom), 12'h400);
		idle(1);
		check(bank_active, 4'h0);
	endtask : access

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h414D));
		rst = 1'b1;
		clk_en = 1'b1;
		req_cke = 1'b1;
		req_cmd = CMD_NOP;
		req_ba = '0;
		req_addr = '0;
		mode = '{3'h0, 3'h3, 3'h2, 1'b0, 1'b0};
		exp_row = '0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		check({bank_active, self_refresh, dll_on, int_clk_on, refresh_pulse, col_issue.valid, burst_valid}, 10'h018);
		idle(3);
		// A frozen edge must not take the activate
		clk_en <= 1'b0;
		send(CMD_ACT, 2'h3, 12'h000);
		clk_en <= 1'b1;
		idle(2);
		check(bank_active, 4'h0);
		for (int it = 0; it < 28; it++) begin
			mode <= '{3'(it % 7), 3'(3 + $urandom_range(3)), 3'(2 + $urandom_range(4)), 1'($urandom), 1'($urandom)};
			idle(2);
			check(read_lat, mode.al + mode.cl);
			check(write_lat, mode.al + mode.cl - 1);
			access(it[0], it[1]);
		end
		for (int b = 0; b < NUM_BANKS; b++) begin
			send(CMD_ACT, BANK_W'(b), 12'h000);
			idle(1);
		end
		check(bank_active, 4'hF);
		send(CMD_PRE, BANK_W'($urandom), ADDR_W'($urandom) | 12'h400);
		idle(1);
		check(bank_active, 4'h0);
		// Eight refreshes in a row, each held off by tRFC, stay within the posting allowance
		for (int r = 0; r < 8; r++) begin
			p0 = pulses;
			send(CMD_REF, BANK_W'($urandom), ADDR_W'($urandom));
			idle(3);
			exp_row = exp_row + 1'b1;
			check(pulses - p0, 1);
			check(refresh_row, exp_row);
			check(bank_active, 4'h0);
			idle(TRFC_CYC);
		end
		check(odt, 1'b0);
		req_cke <= 1'b0;
		send(CMD_REF, 2'h0, 12'h000);
		check(self_refresh, 1'b1);
		idle(1);
		check({self_refresh, dll_on, int_clk_on}, 3'h4);
		idle(2);
		p0 = pulses;
		// Long stay lets the internal timer fire twice while pins carry junk
		idle(2 * SR_TICK_CYC + 40);
		check(pulses - p0, 2);
		check(bank_active, 4'h0);
		req_cke <= 1'b1;
		idle(1);
		check({self_refresh, dll_on, int_clk_on}, 3'h3);
		idle(1);
		check(self_refresh, 1'b0);
		idle(TXSNR_CYC);
		p0 = pulses;
		send(CMD_REF, BANK_W'($urandom), ADDR_W'($urandom));
		idle(3);
		check(pulses - p0, 1);
		idle(TRFC_CYC);
		send(CMD_ACT, 2'h1, 12'h000);
		idle(1);
		check(bank_active, 4'h2);
		close_out();
	end
endmodule : ddr2_command_refresh_access_tb_top
